// file: hw/rsta_turnaround.sv
// Line direction and answer timing for an addressed serial bus slave
`timescale 1ns/1ps
// Operation
// [R1] An answer starts well under 1 ms after the command ends, else dropped; the code drops it only after the full 1 ms.
// [R2] In half duplex the driver stays on at most 2 ms after the last byte.
// [R3] The master turns its own driver off within 100 us after its command.
// [R4] The master waits at least 2 ms after an answer before a new command.
// [R5] Full duplex has separate pairs; half duplex shares one, one driver.
// [R6] Every station turns its driver off right after its last byte.
// [R7] The bus address is 0 after reset unless another default is set.
// [R8] An address change is taken only in calibration mode, else refused.
// [R9] The driver is enabled only to answer a command, never unprompted.
module rsta_turnaround #(
  parameter logic [15:0] ANS_TIMEOUT_CYC = rsta_pkg::ANS_TIMEOUT_CYC,
  parameter logic [15:0] HOLD_MAX_CYC = rsta_pkg::HOLD_MAX_CYC,
  parameter logic [7:0] ADDR_DEFAULT = rsta_pkg::ADDR_RESET
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic half_duplex_pin,
  input wire logic cal_mode_pin,
  input wire logic cmd_done,
  input wire logic [rsta_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic addr_set_valid,
  input wire logic [rsta_pkg::ADDR_W-1:0] addr_set_data,
  output logic addr_set_rejected,
  output logic [rsta_pkg::ADDR_W-1:0] bus_addr,
  input wire logic ans_valid,
  output logic ans_ready,
  input wire logic [rsta_pkg::BYTE_W-1:0] ans_data,
  input wire logic ans_last,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [rsta_pkg::BYTE_W-1:0] tx_data,
  input wire logic tx_busy,
  output logic drv_en,
  output logic rx_en,
  output logic ans_dropped
);
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic [2:0] hd_sync_reg;
  logic [2:0] cal_sync_reg;
  logic hd_reg;
  logic hd_next;
  logic cal_reg;
  logic cal_next;
  rsta_pkg::rsta_state_e state_reg;
  rsta_pkg::rsta_state_e state_next;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic [rsta_pkg::ADDR_W-1:0] addr_reg;
  logic [rsta_pkg::ADDR_W-1:0] addr_next;
  logic rej_reg;
  logic rej_next;
  logic drop_reg;
  logic drop_next;
  logic fifo_valid;
  logic fifo_ready;
  logic [rsta_pkg::BYTE_W:0] fifo_data;

  // Reset release through two stages
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_sync_reg <= 2'h0;
    end
    else
    begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // Pin synchronisers, change counts once stages two and three agree
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hd_sync_reg <= 3'h0;
      cal_sync_reg <= 3'h0;
    end
    else
    begin
      hd_sync_reg <= {hd_sync_reg[1:0], half_duplex_pin};
      cal_sync_reg <= {cal_sync_reg[1:0], cal_mode_pin};
    end
  end

  always_comb
  begin
    hd_next = hd_reg;
    cal_next = cal_reg;
    if (hd_sync_reg[2] == hd_sync_reg[1])
    begin
      hd_next = hd_sync_reg[2];
    end
    if (cal_sync_reg[2] == cal_sync_reg[1])
    begin
      cal_next = cal_sync_reg[2];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hd_reg <= 1'b0;
      cal_reg <= 1'b0;
    end
    else
    begin
      hd_reg <= hd_next;
      cal_reg <= cal_next;
    end
  end

  rsta_fifo #(
    .WIDTH(rsta_pkg::BYTE_W + 1),
    .DEPTH(rsta_pkg::FIFO_DEPTH)
  ) i_rsta_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(ans_valid),
    .in_ready(ans_ready),
    .in_data({ans_last, ans_data}),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_data)
  );

  assign tx_valid = (state_reg == rsta_pkg::RSTA_SEND) && fifo_valid;
  assign fifo_ready = (state_reg == rsta_pkg::RSTA_SEND) && tx_ready;
  assign tx_data = fifo_data[rsta_pkg::BYTE_W-1:0];
  assign drv_en = (state_reg == rsta_pkg::RSTA_SEND) ||
                  (state_reg == rsta_pkg::RSTA_DRAIN); // [R9]
  assign rx_en = !(hd_reg && drv_en); // [R5]
  assign bus_addr = addr_reg;
  assign addr_set_rejected = rej_reg;
  assign ans_dropped = drop_reg;

  // Turnaround sequencer
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg + rsta_pkg::CNT_ONE;
    drop_next = 1'b0;
    unique case (state_reg)
      rsta_pkg::RSTA_IDLE:
      begin
        cnt_next = rsta_pkg::CNT_ZERO;
        if (cmd_done && (cmd_addr == addr_reg))
        begin
          state_next = rsta_pkg::RSTA_WAIT; // [R9]
        end
      end
      rsta_pkg::RSTA_WAIT:
      begin
        if (fifo_valid)
        begin
          state_next = rsta_pkg::RSTA_SEND;
          cnt_next = rsta_pkg::CNT_ZERO;
        end
        else if (cnt_reg == ANS_TIMEOUT_CYC - rsta_pkg::CNT_ONE)
        begin
          state_next = rsta_pkg::RSTA_IDLE; // [R1]
          drop_next = 1'b1;
        end
      end
      rsta_pkg::RSTA_SEND:
      begin
        cnt_next = rsta_pkg::CNT_ZERO;
        if (fifo_valid && tx_ready && fifo_data[rsta_pkg::BYTE_W])
        begin
          state_next = rsta_pkg::RSTA_DRAIN;
        end
      end
      rsta_pkg::RSTA_DRAIN:
      begin
        if (!tx_busy || (cnt_reg == HOLD_MAX_CYC - rsta_pkg::CNT_ONE))
        begin
          state_next = rsta_pkg::RSTA_IDLE; // [R2] [R6]
        end
      end
    endcase
  end

  // Address register, writable only in calibration mode
  always_comb
  begin
    addr_next = addr_reg;
    rej_next = 1'b0;
    if (addr_set_valid)
    begin
      if (cal_reg)
      begin
        addr_next = addr_set_data; // [R8]
      end
      else
      begin
        rej_next = 1'b1; // [R8]
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= rsta_pkg::RSTA_IDLE;
      cnt_reg <= rsta_pkg::CNT_ZERO;
      addr_reg <= ADDR_DEFAULT; // [R7]
      rej_reg <= 1'b0;
      drop_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      addr_reg <= addr_next;
      rej_reg <= rej_next;
      drop_reg <= drop_next;
    end
  end

  // Checks
  property p_ans_bound;
    @(posedge clk) disable iff (!rst_n)
    (state_reg == rsta_pkg::RSTA_WAIT) |-> (cnt_reg < ANS_TIMEOUT_CYC);
  endproperty
  a_ans_bound: assert property (p_ans_bound) // [R1]
    else $error("answer wait overran its limit");
  property p_hold_bound;
    @(posedge clk) disable iff (!rst_n)
    (state_reg == rsta_pkg::RSTA_DRAIN) |-> (cnt_reg < HOLD_MAX_CYC);
  endproperty
  a_hold_bound: assert property (p_hold_bound) // [R2]
    else $error("driver held past its limit");
  property p_release;
    @(posedge clk) disable iff (!rst_n)
    (state_reg == rsta_pkg::RSTA_DRAIN) && !tx_busy |=> !drv_en;
  endproperty
  a_release: assert property (p_release) // [R6]
    else $error("driver not released after last byte");
  property p_one_driver;
    @(posedge clk) disable iff (!rst_n)
    hd_reg && drv_en |-> !rx_en;
  endproperty
  a_one_driver: assert property (p_one_driver) // [R5]
    else $error("receiver open while driving shared pair");
  property p_addr_reset;
    @(posedge clk)
    $rose(rst_n) |-> (addr_reg == ADDR_DEFAULT);
  endproperty
  a_addr_reset: assert property (p_addr_reset) // [R7]
    else $error("address not default after reset");
  property p_addr_reject;
    @(posedge clk) disable iff (!rst_n)
    addr_set_valid && !cal_reg |=>
      (addr_reg == $past(addr_reg)) && addr_set_rejected;
  endproperty
  a_addr_reject: assert property (p_addr_reject) // [R8]
    else $error("address changed outside calibration mode");
  property p_addr_accept;
    @(posedge clk) disable iff (!rst_n)
    addr_set_valid && cal_reg |=>
      (addr_reg == $past(addr_set_data)) && !addr_set_rejected;
  endproperty
  a_addr_accept: assert property (p_addr_accept) // [R8]
    else $error("address change lost in calibration mode");
  property p_prompted;
    @(posedge clk) disable iff (!rst_n)
    $rose(drv_en) |-> ($past(state_reg) == rsta_pkg::RSTA_WAIT);
  endproperty
  a_prompted: assert property (p_prompted) // [R9]
    else $error("driver enabled without a command");
  property p_cov_answer;
    @(posedge clk) disable iff (!rst_n)
    (state_reg == rsta_pkg::RSTA_DRAIN) ##1
      (state_reg == rsta_pkg::RSTA_IDLE);
  endproperty
  c_cov_answer: cover property (p_cov_answer);
  property p_cov_drop;
    @(posedge clk) disable iff (!rst_n)
    ans_dropped;
  endproperty
  c_cov_drop: cover property (p_cov_drop);
  property p_cov_addr;
    @(posedge clk) disable iff (!rst_n)
    addr_set_valid && cal_reg;
  endproperty
  c_cov_addr: cover property (p_cov_addr);
endmodule

// file: hw/rsta_pkg.sv
// Shared constants for the bus slave turnaround block
package rsta_pkg;
  localparam int CLK_MHZ = 10;
  localparam int ANS_TIME_US = 1000;
  localparam int HOLD_TIME_US = 2000;
  localparam logic [15:0] ANS_TIMEOUT_CYC = 16'(ANS_TIME_US * CLK_MHZ);
  localparam logic [15:0] HOLD_MAX_CYC = 16'(HOLD_TIME_US * CLK_MHZ);
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 4;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  typedef enum logic [1:0] {
    RSTA_IDLE,
    RSTA_WAIT,
    RSTA_SEND,
    RSTA_DRAIN
  } rsta_state_e;
endpackage

// file: hw/rsta_fifo.sv
// Small first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ps
module rsta_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] wr_ptr_next;
  logic [AW:0] rd_ptr_reg;
  logic [AW:0] rd_ptr_next;
  logic do_wr;
  logic do_rd;

  // Full when pointers differ only in the wrap bit
  assign in_ready = (wr_ptr_reg != {~rd_ptr_reg[AW], rd_ptr_reg[AW-1:0]});
  assign out_valid = (wr_ptr_reg != rd_ptr_reg);
  assign out_data = mem_reg[rd_ptr_reg[AW-1:0]];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  always_comb
  begin
    wr_ptr_next = do_wr ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
    rd_ptr_next = do_rd ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
    end
  end

  // Storage array has no reset
  always_ff @(posedge clk)
  begin
    if (do_wr)
    begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end
endmodule

// file: sim/rsta_serial_model.sv
// Serializer stand-in on the transmit side
`timescale 1ns/1ps
module rsta_serial_model (
  input wire logic clk,
  input wire logic slow,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic tx_busy
);
  int cnt = 0;
  // One byte at a time, shifter busy after each
  assign tx_ready = (cnt == 0);
  assign tx_busy = (cnt != 0);
  always @(posedge clk)
  begin
    if (tx_valid && tx_ready)
      cnt <= slow ? 200 : 6;
    else if (cnt != 0)
      cnt <= cnt - 1;
  end
endmodule

// file: sim/rsta_turnaround_tb.sv
// Self-checking bench for the turnaround block
`timescale 1ns/1ps
module rsta_turnaround_tb;
  localparam int ANS = 50;
  localparam int HOLD = 80;
  logic clk = 0, rst_b = 0, hd = 0, cal = 0, cmd_done = 0, as_v = 0;
  logic ans_valid = 0, ans_last = 0, slow = 0;
  logic [7:0] cmd_addr = 8'h00, as_d = 8'h00, ans_data = 8'h00;
  logic as_rej, ans_ready, tx_valid, tx_ready, tx_busy;
  logic drv_en, rx_en, ans_dropped;
  logic [7:0] bus_addr, tx_data, a, exp_addr;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'h00017729;
  int err_count = 0, checks = 0, n, cyc = 0, last_hs = 0;

  rsta_turnaround #(.ANS_TIMEOUT_CYC(16'h0032), .HOLD_MAX_CYC(16'h0050))
    i_rsta_turnaround (.clk(clk), .rst_b(rst_b), .half_duplex_pin(hd),
    .cal_mode_pin(cal), .cmd_done(cmd_done), .cmd_addr(cmd_addr),
    .addr_set_valid(as_v), .addr_set_data(as_d),
    .addr_set_rejected(as_rej), .bus_addr(bus_addr),
    .ans_valid(ans_valid), .ans_ready(ans_ready), .ans_data(ans_data),
    .ans_last(ans_last), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .tx_busy(tx_busy), .drv_en(drv_en),
    .rx_en(rx_en), .ans_dropped(ans_dropped));
  rsta_serial_model i_rsta_serial_model (.clk(clk), .slow(slow),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_busy(tx_busy));

  initial
  begin
    forever #50 clk = ~clk;
  end

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  task check(string what, logic [7:0] seen, logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task results();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task hang(string what);
    err_count++;
    $display("[FAIL] %s expected event seen none", what);
    results();
  endtask

  task wait_drv(logic v, int lim);
    n = 0;
    while (drv_en !== v)
    begin
      @(negedge clk);
      n++;
      if (n > lim)
        hang("drv_en");
    end
  endtask

  task set_addr(logic [7:0] d, logic ok);
    @(negedge clk);
    as_v = 1;
    as_d = d;
    @(negedge clk);
    as_v = 0;
    if (ok)
      exp_addr = d;
    check("addr_set_rejected", 8'(as_rej), 8'(!ok));
    check("bus_addr", bus_addr, exp_addr);
  endtask

  task cmd(logic [7:0] d);
    @(negedge clk);
    cmd_done = 1;
    cmd_addr = d;
    @(negedge clk);
    cmd_done = 0;
  endtask

  task push(logic last);
    @(negedge clk);
    ans_valid = 1;
    ans_data = rnd();
    ans_last = last;
    n = 0;
    while (ans_ready !== 1)
    begin
      @(negedge clk);
      n++;
      if (n > 2000)
        hang("ans_ready");
    end
    exp_q.push_back(ans_data);
    @(negedge clk);
    ans_valid = 0;
  endtask

  // Cycle count for the hold window
  always @(posedge clk)
  begin
    cyc++;
  end

  // Byte order on the line, seen while the handshake stands
  always @(negedge clk)
  begin
    if (tx_valid === 1 && tx_ready === 1)
    begin
      last_hs = cyc;
      if (exp_q.size() == 0)
        check("tx_extra", 8'h01, 8'h00);
      else
        check("tx_data", tx_data, exp_q.pop_front());
    end
  end

  always @(negedge clk)
  begin
    if (drv_en === 1)
      check("rx_en", 8'(rx_en), 8'(!hd));
  end

  initial
  begin
    exp_addr = 8'h00;
    repeat (5) @(negedge clk);
    rst_b = 1;
    repeat (8) @(negedge clk);
    check("bus_addr", bus_addr, 8'h00);
    check("rx_en", 8'(rx_en), 8'h01);
    $display("test reset finished");
    a = rnd() | 8'h01;
    set_addr(a, 0);
    cal = 1;
    repeat (6) @(negedge clk);
    set_addr(a, 1);
    cal = 0;
    $display("test address finished");
    cmd(a);
    n = 0;
    while (ans_dropped !== 1)
    begin
      @(negedge clk);
      n++;
      if (n > ANS + 5)
        hang("ans_dropped");
    end
    check("drop_time", 8'(n), 8'(ANS));
    check("drv_en", 8'(drv_en), 8'h00);
    $display("test timeout finished");
    slow = 1;
    repeat (3) push(0);
    push(1);
    check("ans_ready", 8'(ans_ready), 8'h00);
    cmd(~a);
    repeat (20)
    begin
      @(negedge clk);
      check("drv_en", 8'(drv_en), 8'h00);
    end
    repeat (100) @(negedge clk);
    cmd(a);
    wait_drv(1, 5);
    wait_drv(0, 4 * 200 + HOLD + 20);
    // Driver held for exactly the hold limit after the last byte
    n = cyc - last_hs - 1;
    check("hold", 8'(n), 8'(HOLD));
    check("tx_busy", 8'(tx_busy), 8'h01);
    $display("test slow answer finished");
    hd = 1;
    slow = 0;
    repeat (100) @(negedge clk);
    cmd(a);
    push(0);
    push(1);
    wait_drv(1, 5);
    wait_drv(0, 50);
    check("tx_busy", 8'(tx_busy), 8'h00);
    check("rx_en", 8'(rx_en), 8'h01);
    check("queue", 8'(exp_q.size()), 8'h00);
    $display("test half duplex finished");
    results();
  end
endmodule
